//--- core/tcc_pkg.sv
// Constants and carriers for the timer capture/compare unit.
// Assumes a single 100 MHz core clock and an 8-bit special-function register port.
package tcc_pkg;

   // ==========================================================
   // Register addresses on the special-function register port.
   localparam logic [7:0] TCC_ADDR_EVENT_FLAGS = 8'hC8;
   localparam logic [7:0] TCC_ADDR_TIMER_CTRL = 8'hEA;
   localparam logic [7:0] TCC_ADDR_CAPT_EDGE = 8'hEB;
   localparam logic [7:0] TCC_ADDR_SET_EN = 8'hEE;
   localparam logic [7:0] TCC_ADDR_CLR_TGL_EN = 8'hEF;
   localparam logic [7:0] TCC_ADDR_CNT_LO = 8'hEC;
   localparam logic [7:0] TCC_ADDR_CNT_HI = 8'hED;
   localparam logic [7:0] TCC_ADDR_PORT4 = 8'hC0;
   // Compare n low byte sits at base + 2n, high byte at base + 2n + 1.
   localparam logic [7:0] TCC_ADDR_CMP_BASE = 8'hD1;
   // Capture n low byte sits at base + 2n, high byte at base + 2n + 1.
   localparam logic [7:0] TCC_ADDR_CAPT_BASE = 8'hA1;

   // ==========================================================
   // Field positions in the timer control register.
   localparam int TCC_TC_WIDE_SEL = 7;
   localparam int TCC_TC_BYTE_SEL = 6;
   localparam int TCC_TC_EXT_RST_EN = 5;
   localparam int TCC_TC_BYTE_FLAG = 4;
   localparam int TCC_TC_PRESC_LO = 2;
   localparam int TCC_TC_SRC_LO = 0;
   // Field positions in the event flag register.
   localparam int TCC_EF_WIDE_OVF = 7;
   localparam int TCC_EF_CMP_LO = 4;
   localparam int TCC_EF_CAPT_LO = 0;

   // ==========================================================
   // Reset values.
   localparam logic [7:0] TCC_RST_REG8 = 8'h00;
   localparam logic [15:0] TCC_RST_REG16 = 16'h0000;

   // ==========================================================
   // Timing: the internal count source is one twelfth of the oscillator.
   localparam int TCC_OSC_DIV = 12;
   localparam logic [3:0] TCC_OSC_DIV_LAST = 4'(TCC_OSC_DIV - 1);

   // Count source selection codes.
   typedef enum logic [1:0]
   {
      TCC_SRC_HALT = 2'b00,
      TCC_SRC_OSC12 = 2'b01,
      TCC_SRC_TEST = 2'b10,
      TCC_SRC_PIN = 2'b11
   } tcc_src_e;

   // Register read or write request from the core.
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tcc_sfr_req_s;

   // Pins that face the outside world.
   typedef struct packed
   {
      logic [3:0] capture_in;
      logic ext_counter_reset_in;
      logic ext_count_in;
   } tcc_pins_s;

endpackage : tcc_pkg

//--- core/tcc_unit.sv
// Timer capture/compare unit: 16-bit counter, four captures, three compares, port four.
// Assumes the core drives the register port synchronously to mclk_i; pins are asynchronous.
`timescale 1ns/10ps
// Functional notes
// - Prescaler divides the count source by 1, 2, 4 or 8 per code.
// - Source code 00 halts, 01 is oscillator/12, 11 is external pin rising edges.
// - Wide overflow requests interrupt only with control bit 7 set.
// - Byte overflow requests interrupt only with control bit 6 set.
// - Low byte overflow sets control bit 4.
// - External counter reset acts only while control bit 5 is set.
// - Capture control bit 2n+1 enables capture on falling edge of input n.
// - Capture control bit 2n enables rising edge; both bits give either edge.
// - Event flags: bit 7 wide overflow, 6..4 compares, 3..0 captures.
// - Interrupt enable and priority live outside this block.
// - Compare 0 match sets port bits 0..5 whose set-enable bit is high.
// - Set-enable bits 7 and 6 report next toggle direction of port bits 7 and 6.
// - Set-enable bits 7 and 6 are read only.
// - Compare 1 match clears port bits 0..5 whose clear-enable bit is high.
// - Compare 2 match sets port bits 7 and 6 whose toggle-enable bit is high to the inverse of set-enable bits 7 and 6.
// - Bits with clear/toggle-enable low ignore compare 1 and 2 matches.
// - Eight separate requests: four capture, three compare, one shared overflow.
// - Capture flags rise on selected edges whether or not the value is read.
// - Selected edge copies counter into capture register n and sets its flag.
// - Counter is not loadable; clears on reset or enabled external rising edge.
// - Prescaler clears when divider or source changes, or counter resets.
// - Hardware never clears flags; software clears them.
module tcc_unit
(
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Special-function register port.
   input wire tcc_pkg::tcc_sfr_req_s sfr_req_i,
   output logic [7:0] sfr_rdata_o,
   // Pins.
   input wire tcc_pkg::tcc_pins_s pins_i,
   output logic [7:0] output_port_four_o,
   // Interrupt requests: [3:0] capture, [6:4] compare, [7] overflow.
   output logic [7:0] irq_o
);
   import tcc_pkg::*;
   // ==========================================================
   // Registers.
   logic [7:0] timer_control_q;
   logic [7:0] capture_edge_control_q;
   logic [7:0] timer_event_flags_q;
   logic [7:0] match_set_enable_q;
   logic [7:0] match_clear_toggle_enable_q;
   logic [7:0] port_q;
   logic [15:0] cnt_q;
   logic [15:0] cmp_q [3];
   logic [15:0] capt_q [4];
   logic [7:0] rdata_q;
   logic [3:0] osc_div_q;
   logic [2:0] presc_q;
   logic cnt_upd_q;
   // Synchronisers: stage one feeds stage two only; stage three holds history for edges.
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic [5:0] sync3_q;
   logic wr_ctrl;
   logic src_tick;
   logic presc_tick;
   logic ext_rst;
   logic byte_ovf;
   logic wide_ovf;
   logic [3:0] capt_ev;
   logic [2:0] cmp_match;
   logic [2:0] presc_mask;
   tcc_src_e src;
   assign wr_ctrl = sfr_req_i.wr && (sfr_req_i.addr == TCC_ADDR_TIMER_CTRL);
   assign src = tcc_src_e'(timer_control_q[TCC_TC_SRC_LO +: 2]);
   // ==========================================================
   // Pin synchronisers, two flops before any logic looks.
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         {sync3_q, sync2_q, sync1_q} <= 18'h00000;
      end
      else
      begin
         {sync3_q, sync2_q, sync1_q} <= {sync2_q, sync1_q, pins_i};
      end
   end
   // ==========================================================
   // Count source: oscillator divided by twelve, or external pin rising edges.
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         osc_div_q <= 4'h0;
      end
      else
      begin
         osc_div_q <= (osc_div_q == TCC_OSC_DIV_LAST) ? 4'h0 : osc_div_q + 4'h1;
      end
   end
   always_comb
   begin
      case (src)
         TCC_SRC_OSC12: src_tick = (osc_div_q == TCC_OSC_DIV_LAST);
         TCC_SRC_PIN: src_tick = sync2_q[0] && !sync3_q[0];
         // Halt, and the test code which software must not use, never count.
         default: src_tick = 1'b0;
      endcase
   end
   assign ext_rst = timer_control_q[TCC_TC_EXT_RST_EN] && sync2_q[1] && !sync3_q[1];
   assign presc_mask = (3'h1 << timer_control_q[TCC_TC_PRESC_LO +: 2]) - 3'h1;
   assign presc_tick = src_tick && ((presc_q & presc_mask) == presc_mask);
   // Prescaler; a stale partial count would skew the first period after a change.
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         presc_q <= 3'h0;
      end
      else if (ext_rst || (wr_ctrl && (sfr_req_i.wdata[3:0] != timer_control_q[3:0])))
      begin
         presc_q <= 3'h0;
      end
      else if (src_tick)
      begin
         presc_q <= presc_q + 3'h1;
      end
   end
   // ==========================================================
   // Counter: no software load path, only reset and increment.
   assign byte_ovf = presc_tick && !ext_rst && (cnt_q[7:0] == 8'hFF);
   assign wide_ovf = presc_tick && !ext_rst && (cnt_q == 16'hFFFF);
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_q <= TCC_RST_REG16;
         cnt_upd_q <= 1'b0;
      end
      else
      begin
         cnt_q <= ext_rst ? TCC_RST_REG16 : cnt_q + 16'(presc_tick);
         cnt_upd_q <= ext_rst || presc_tick;
      end
   end
   // ==========================================================
   // Compare and capture channels.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_chan
         assign capt_ev[gi] = (capture_edge_control_q[2 * gi] && sync2_q[2 + gi] && !sync3_q[2 + gi]) ||
                              (capture_edge_control_q[2 * gi + 1] && !sync2_q[2 + gi] && sync3_q[2 + gi]);
         always_ff @(posedge mclk_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               capt_q[gi] <= TCC_RST_REG16;
            end
            else if (capt_ev[gi])
            begin
               capt_q[gi] <= cnt_q;
            end
         end
         if (gi < 3)
         begin : g_cmp
            assign cmp_match[gi] = cnt_upd_q && (cnt_q == cmp_q[gi]);
            // Compare registers, byte-writable.
            always_ff @(posedge mclk_i or negedge rstn_i)
            begin
               if (!rstn_i)
               begin
                  cmp_q[gi] <= TCC_RST_REG16;
               end
               else if (sfr_req_i.wr && (sfr_req_i.addr == TCC_ADDR_CMP_BASE + 8'(2 * gi)))
               begin
                  cmp_q[gi][7:0] <= sfr_req_i.wdata;
               end
               else if (sfr_req_i.wr && (sfr_req_i.addr == TCC_ADDR_CMP_BASE + 8'(2 * gi + 1)))
               begin
                  cmp_q[gi][15:8] <= sfr_req_i.wdata;
               end
            end
         end
      end
   endgenerate
   // ==========================================================
   // Control registers written by software.
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         timer_control_q <= TCC_RST_REG8;
         capture_edge_control_q <= TCC_RST_REG8;
         match_clear_toggle_enable_q <= TCC_RST_REG8;
      end
      else
      begin
         if (wr_ctrl)
         begin
            timer_control_q <= sfr_req_i.wdata;
         end
         if (byte_ovf)
         begin
            timer_control_q[TCC_TC_BYTE_FLAG] <= 1'b1;
         end
         if (sfr_req_i.wr && (sfr_req_i.addr == TCC_ADDR_CAPT_EDGE))
         begin
            capture_edge_control_q <= sfr_req_i.wdata;
         end
         if (sfr_req_i.wr && (sfr_req_i.addr == TCC_ADDR_CLR_TGL_EN))
         begin
            match_clear_toggle_enable_q <= sfr_req_i.wdata;
         end
      end
   end
   // Event flags: software writes the value, hardware only sets.
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         timer_event_flags_q <= TCC_RST_REG8;
      end
      else
      begin
         timer_event_flags_q <= ((sfr_req_i.wr && (sfr_req_i.addr == TCC_ADDR_EVENT_FLAGS)) ?
                                sfr_req_i.wdata : timer_event_flags_q) |
                                {wide_ovf, cmp_match, capt_ev};
      end
   end
   // ==========================================================
   // Port four and the toggle-direction bits.
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         port_q <= TCC_RST_REG8;
         match_set_enable_q <= TCC_RST_REG8;
      end
      else
      begin
         if (sfr_req_i.wr && (sfr_req_i.addr == TCC_ADDR_SET_EN))
         begin
            match_set_enable_q[5:0] <= sfr_req_i.wdata[5:0];
         end
         // Software writes first; match actions below override the same cycle.
         if (sfr_req_i.wr && (sfr_req_i.addr == TCC_ADDR_PORT4))
         begin
            port_q <= sfr_req_i.wdata;
         end
         if (cmp_match[0])
         begin
            port_q[5:0] <= port_q[5:0] | match_set_enable_q[5:0];
         end
         if (cmp_match[1])
         begin
            port_q[5:0] <= (cmp_match[0] ? (port_q[5:0] | match_set_enable_q[5:0]) : port_q[5:0]) &
                           ~match_clear_toggle_enable_q[5:0];
         end
         if (cmp_match[2])
         begin
            for (int i = 6; i < 8; i++)
            begin
               if (match_clear_toggle_enable_q[i])
               begin
                  port_q[i] <= ~match_set_enable_q[i];
                  match_set_enable_q[i] <= ~match_set_enable_q[i];
               end
            end
         end
      end
   end
   // ==========================================================
   // Registered read mux; unmapped addresses read zero.
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdata_q <= TCC_RST_REG8;
      end
      else if (sfr_req_i.rd)
      begin
         case (sfr_req_i.addr)
            TCC_ADDR_EVENT_FLAGS: rdata_q <= timer_event_flags_q;
            TCC_ADDR_TIMER_CTRL: rdata_q <= timer_control_q;
            TCC_ADDR_CAPT_EDGE: rdata_q <= capture_edge_control_q;
            TCC_ADDR_SET_EN: rdata_q <= match_set_enable_q;
            TCC_ADDR_CLR_TGL_EN: rdata_q <= match_clear_toggle_enable_q;
            TCC_ADDR_PORT4: rdata_q <= port_q;
            // No shadow latch: a read across a low-byte carry can tear.
            TCC_ADDR_CNT_LO: rdata_q <= cnt_q[7:0];
            TCC_ADDR_CNT_HI: rdata_q <= cnt_q[15:8];
            TCC_ADDR_CMP_BASE: rdata_q <= cmp_q[0][7:0];
            TCC_ADDR_CMP_BASE + 8'h01: rdata_q <= cmp_q[0][15:8];
            TCC_ADDR_CMP_BASE + 8'h02: rdata_q <= cmp_q[1][7:0];
            TCC_ADDR_CMP_BASE + 8'h03: rdata_q <= cmp_q[1][15:8];
            TCC_ADDR_CMP_BASE + 8'h04: rdata_q <= cmp_q[2][7:0];
            TCC_ADDR_CMP_BASE + 8'h05: rdata_q <= cmp_q[2][15:8];
            TCC_ADDR_CAPT_BASE: rdata_q <= capt_q[0][7:0];
            TCC_ADDR_CAPT_BASE + 8'h01: rdata_q <= capt_q[0][15:8];
            TCC_ADDR_CAPT_BASE + 8'h02: rdata_q <= capt_q[1][7:0];
            TCC_ADDR_CAPT_BASE + 8'h03: rdata_q <= capt_q[1][15:8];
            TCC_ADDR_CAPT_BASE + 8'h04: rdata_q <= capt_q[2][7:0];
            TCC_ADDR_CAPT_BASE + 8'h05: rdata_q <= capt_q[2][15:8];
            TCC_ADDR_CAPT_BASE + 8'h06: rdata_q <= capt_q[3][7:0];
            TCC_ADDR_CAPT_BASE + 8'h07: rdata_q <= capt_q[3][15:8];
            default: rdata_q <= 8'h00;
         endcase
      end
   end
   // ==========================================================
   // Outputs; enabling and priority of the requests are applied elsewhere.
   assign sfr_rdata_o = rdata_q;
   assign output_port_four_o = port_q;
   assign irq_o[6:0] = timer_event_flags_q[6:0];
   assign irq_o[7] = (timer_event_flags_q[TCC_EF_WIDE_OVF] && timer_control_q[TCC_TC_WIDE_SEL]) ||
                     (timer_control_q[TCC_TC_BYTE_FLAG] && timer_control_q[TCC_TC_BYTE_SEL]);
endmodule : tcc_unit

//--- verification/tcc_core_model.sv
// Core model that drives the register port of the timer capture/compare unit.
// Assumes each call starts just after a rising clock edge, one access at a time.
`timescale 1ns/10ps
// ==========
// Core model
module tcc_core_model
   import tcc_pkg::*;
(
   // Clock.
   input wire logic mclk_i,
   // Register port.
   output tcc_pkg::tcc_sfr_req_s sfr_req_o,
   input wire logic [7:0] sfr_rdata_i
);
   // Idle port at time zero.
   initial sfr_req_o = '0;

   // One-cycle write strobe; the released bus shows inverted values so stale data cannot pass.
   task sfr_wr(input logic [7:0] addr, input logic [7:0] data);
      sfr_req_o = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge mclk_i);
      #1 sfr_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
      @(posedge mclk_i);
      #1;
   endtask : sfr_wr

   // One-cycle read strobe; data is taken one edge later, where it stands until the next read.
   task sfr_rd(input logic [7:0] addr, output logic [7:0] data);
      sfr_req_o = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge mclk_i);
      #1 sfr_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
      @(posedge mclk_i);
      #1 data = sfr_rdata_i;
   endtask : sfr_rd

   task clear_flags;
      sfr_wr(TCC_ADDR_EVENT_FLAGS, 8'h00);
   endtask : clear_flags
endmodule : tcc_core_model

//--- verification/tcc_unit_sva.sv
// Port-level checker for the timer capture/compare unit, bound to its top module.
// Assumes one clock and read data that appears one edge after the read strobe.
`timescale 1ns/10ps
// ==========
// Checker
module tcc_unit_sva
   import tcc_pkg::*;
(
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Register port.
   input wire tcc_pkg::tcc_sfr_req_s sfr_req_i,
   input wire logic [7:0] sfr_rdata_o,
   // Pins and outputs.
   input wire tcc_pkg::tcc_pins_s pins_i,
   input wire logic [7:0] output_port_four_o,
   input wire logic [7:0] irq_o
);
   logic [23:0] capt_hist_q;
   logic [3:0] capt_chg;

   // Six past pin samples; the synchroniser delay fits well inside them.
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         capt_hist_q <= '0;
      end
      else
      begin
         capt_hist_q <= {capt_hist_q[19:0], pins_i.capture_in};
      end
   end

   // A pin has moved if any two neighbouring samples differ.
   always_comb
   begin
      capt_chg = capt_hist_q[3:0] ^ pins_i.capture_in;
      for (int i = 0; i < 5; i++)
      begin
         capt_chg = capt_chg | (capt_hist_q[4*i +: 4] ^ capt_hist_q[4*i+4 +: 4]);
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);

   // Register accesses as taken at an edge.
   sequence s_wr(logic [7:0] a);
      sfr_req_i.wr && sfr_req_i.addr == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      sfr_req_i.rd && sfr_req_i.addr == a;
   endsequence

   property p_flag_no_hw_clear;
      |(~irq_o[6:0] & $past(irq_o[6:0])) |-> $past(sfr_req_i.wr) && $past(sfr_req_i.addr) == TCC_ADDR_EVENT_FLAGS;
   endproperty
   a_flag_no_hw_clear: assert property (p_flag_no_hw_clear) else $error("Flag fell without a flag write.");
   property p_flags_read;
      s_rd(TCC_ADDR_EVENT_FLAGS) |=> sfr_rdata_o[6:0] == $past(irq_o[6:0]);
   endproperty
   a_flags_read: assert property (p_flags_read) else $error("Flag read differs from request lines.");
   property p_ovf_gated;
      s_rd(TCC_ADDR_TIMER_CTRL) |=> !sfr_rdata_o[7] && !(sfr_rdata_o[6] && sfr_rdata_o[4]) |-> !$past(irq_o[7]);
   endproperty
   a_ovf_gated: assert property (p_ovf_gated) else $error("Overflow request without selection.");
   property p_byte_ovf_req;
      s_rd(TCC_ADDR_TIMER_CTRL) |=> sfr_rdata_o[6] && sfr_rdata_o[4] |-> $past(irq_o[7]);
   endproperty
   a_byte_ovf_req: assert property (p_byte_ovf_req) else $error("Selected byte overflow not requested.");
   property p_ste_write;
      s_wr(TCC_ADDR_SET_EN) ##2 s_rd(TCC_ADDR_SET_EN) |=> sfr_rdata_o[5:0] == $past(sfr_req_i.wdata[5:0], 3);
   endproperty
   a_ste_write: assert property (p_ste_write) else $error("Set enable bits did not take the write.");
   property p_capt_flag_cause;
      |(irq_o[3:0] & ~$past(irq_o[3:0]) & ~capt_chg) |-> $past(sfr_req_i.wr) && $past(sfr_req_i.addr) == TCC_ADDR_EVENT_FLAGS;
   endproperty
   a_capt_flag_cause: assert property (p_capt_flag_cause) else $error("Capture flag rose with no pin edge.");
   property p_reset_clear;
      $rose(rstn_i) |-> irq_o == 8'h00 && output_port_four_o == 8'h00 && sfr_rdata_o == 8'h00;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("Outputs not clear after reset.");
   property p_flag_write;
      s_wr(TCC_ADDR_EVENT_FLAGS) |=> (irq_o[6:0] & $past(sfr_req_i.wdata[6:0])) == $past(sfr_req_i.wdata[6:0]);
   endproperty
   a_flag_write: assert property (p_flag_write) else $error("Request line does not follow its flag.");
endmodule : tcc_unit_sva

bind tcc_unit tcc_unit_sva tcc_unit_sva_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .sfr_req_i(sfr_req_i),
   .sfr_rdata_o(sfr_rdata_o), .pins_i(pins_i), .output_port_four_o(output_port_four_o), .irq_o(irq_o));

//--- verification/tcc_unit_tb.sv
// Self-checking bench for the timer capture/compare unit.
// Assumes the core model drives the register port and the bench drives every pin.
`timescale 1ns/10ps
// ==========
// Bench top
module tcc_unit_tb;
   import tcc_pkg::*;
   logic mclk;
   logic rst_n;
   tcc_sfr_req_s sfr_req;
   tcc_pins_s pins;
   logic [7:0] rdata;
   logic [7:0] port4;
   logic [7:0] irq;
   int bad_count;
   int total_checks;
   logic [15:0] c0;
   logic [15:0] c1;
   logic [7:0] b;
   // Registers that must read zero after reset; the lowest byte is an unmapped address.
   localparam logic [63:0] RST_ADDRS = {TCC_ADDR_EVENT_FLAGS, TCC_ADDR_TIMER_CTRL, TCC_ADDR_CAPT_EDGE,
      TCC_ADDR_SET_EN, TCC_ADDR_CLR_TGL_EN, TCC_ADDR_PORT4, TCC_ADDR_CNT_LO, 8'h00};

   tcc_unit tcc_unit_i (.mclk_i(mclk), .rstn_i(rst_n), .sfr_req_i(sfr_req), .sfr_rdata_o(rdata),
      .pins_i(pins), .output_port_four_o(port4), .irq_o(irq));
   tcc_core_model tcc_core_model_i (.mclk_i(mclk), .sfr_req_o(sfr_req), .sfr_rdata_i(rdata));

   // 100 MHz clock.
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task reg_wr(input logic [7:0] a, input logic [7:0] d);
      tcc_core_model_i.sfr_wr(a, d);
   endtask : reg_wr
   task chk_reg(input logic [7:0] a, input logic [7:0] e);
      tcc_core_model_i.sfr_rd(a, b);
      chk({8'h00, b}, {8'h00, e});
   endtask : chk_reg
   // The counter has no read latch, so it is only read while no pulses arrive.
   task rd16(input logic [7:0] a, output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      tcc_core_model_i.sfr_rd(a, lo);
      tcc_core_model_i.sfr_rd(a + 8'h01, hi);
      v = {hi, lo};
   endtask : rd16
   task wr16(input logic [7:0] a, input logic [15:0] v);
      reg_wr(a, v[7:0]);
      reg_wr(a + 8'h01, v[15:8]);
   endtask : wr16
   // Pin bit 0 is the count pin, bit 1 the counter reset; pulses are long enough to pass the synchroniser.
   task pulse(input logic to_reset, input int n);
      repeat (n)
      begin
         pins[to_reset] = 1'b1;
         tick(2);
         pins[to_reset] = 1'b0;
         tick(2);
      end
      tick(4);
   endtask : pulse
   task end_sim;
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   // Watchdog, far beyond the roughly 1,600 cycles the tests need.
   initial
   begin
      #300000;
      bad_count++;
      end_sim();
   end

   // Main sequence.
   initial
   begin
      rst_n = 1'b0;
      pins = '0;
      bad_count = 0;
      total_checks = 0;
      repeat (8) @(posedge mclk);
      #1 rst_n = 1'b1;
      reg_wr(8'h00, 8'hFF);
      reg_wr(TCC_ADDR_CNT_LO, 8'hFF);
      for (int i = 0; i < 8; i++)
         chk_reg(RST_ADDRS[i*8 +: 8], 8'h00);
      for (int i = 0; i < 6; i++)
         chk_reg(TCC_ADDR_CMP_BASE + 8'(i), 8'h00);
      reg_wr(TCC_ADDR_SET_EN, 8'hFF);
      chk_reg(TCC_ADDR_SET_EN, 8'h3F);
      reg_wr(TCC_ADDR_SET_EN, 8'h00);
      // Count source and prescaler on pin pulses, where every count is exact; the oscillator source is then checked within a range.
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h03);
      pulse(1'b0, 3);
      chk_reg(TCC_ADDR_CNT_LO, 8'h03);
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h00);
      pulse(1'b0, 2);
      chk_reg(TCC_ADDR_CNT_LO, 8'h03);
      // The forbidden test code must not count either.
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h02);
      pulse(1'b0, 2);
      chk_reg(TCC_ADDR_CNT_LO, 8'h03);
      for (int p = 0; p < 4; p++)
      begin
         reg_wr(TCC_ADDR_TIMER_CTRL, 8'h03 | (8'(p) << 2));
         rd16(TCC_ADDR_CNT_LO, c0);
         pulse(1'b0, 8);
         rd16(TCC_ADDR_CNT_LO, c1);
         chk(c1, c0 + (16'h0008 >> p));
      end
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h01);
      rd16(TCC_ADDR_CNT_LO, c0);
      tick(120);
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h00);
      rd16(TCC_ADDR_CNT_LO, c1);
      chk({15'h0000, (c1 - c0) >= 16'h0009 && (c1 - c0) <= 16'h000B}, 16'h0001);
      // External counter reset, disabled and then enabled with a half-full prescaler.
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h03);
      rd16(TCC_ADDR_CNT_LO, c0);
      pulse(1'b1, 1);
      rd16(TCC_ADDR_CNT_LO, c1);
      chk(c1, c0);
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h27);
      pulse(1'b0, 1);
      pulse(1'b1, 1);
      pulse(1'b0, 1);
      rd16(TCC_ADDR_CNT_LO, c1);
      chk(c1, 16'h0000);
      pulse(1'b0, 1);
      rd16(TCC_ADDR_CNT_LO, c1);
      chk(c1, 16'h0001);
      // Captures: input 0 rising, 1 falling, 2 both, 3 none.
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h03);
      tcc_core_model_i.clear_flags();
      reg_wr(TCC_ADDR_CAPT_EDGE, 8'h39);
      rd16(TCC_ADDR_CNT_LO, c0);
      pins.capture_in = 4'hF;
      tick(6);
      chk_reg(TCC_ADDR_EVENT_FLAGS, 8'h05);
      rd16(TCC_ADDR_CAPT_BASE, c1);
      chk(c1, c0);
      pulse(1'b0, 2);
      pins.capture_in = 4'h0;
      tick(6);
      chk_reg(TCC_ADDR_EVENT_FLAGS, 8'h07);
      rd16(TCC_ADDR_CAPT_BASE + 8'h02, c1);
      chk(c1, c0 + 16'h0002);
      rd16(TCC_ADDR_CAPT_BASE + 8'h04, c1);
      chk(c1, c0 + 16'h0002);
      rd16(TCC_ADDR_CAPT_BASE + 8'h06, c1);
      chk(c1, 16'h0000);
      chk({8'h00, irq}, 16'h0007);
      tcc_core_model_i.clear_flags();
      chk_reg(TCC_ADDR_EVENT_FLAGS, 8'h00);
      // Compares: set at +2, toggle at +3, clear at +4.
      reg_wr(TCC_ADDR_SET_EN, 8'h05);
      reg_wr(TCC_ADDR_CLR_TGL_EN, 8'hC3);
      rd16(TCC_ADDR_CNT_LO, c0);
      wr16(TCC_ADDR_CMP_BASE, c0 + 16'h0002);
      wr16(TCC_ADDR_CMP_BASE + 8'h02, c0 + 16'h0004);
      wr16(TCC_ADDR_CMP_BASE + 8'h04, c0 + 16'h0003);
      pulse(1'b0, 2);
      chk({8'h00, port4}, 16'h0005);
      chk_reg(TCC_ADDR_EVENT_FLAGS, 8'h10);
      pulse(1'b0, 1);
      chk({8'h00, port4}, 16'h00C5);
      chk_reg(TCC_ADDR_SET_EN, 8'hC5);
      pulse(1'b0, 1);
      chk({8'h00, port4}, 16'h00C4);
      chk({8'h00, irq}, 16'h0070);
      // Byte overflow and the shared overflow request.
      tcc_core_model_i.clear_flags();
      tcc_core_model_i.sfr_rd(TCC_ADDR_CNT_LO, b);
      pulse(1'b0, 256 - int'(b));
      chk_reg(TCC_ADDR_TIMER_CTRL, 8'h13);
      chk({15'h0000, irq[7]}, 16'h0000);
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h53);
      chk_reg(TCC_ADDR_TIMER_CTRL, 8'h53);
      chk({15'h0000, irq[7]}, 16'h0001);
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h03);
      reg_wr(TCC_ADDR_EVENT_FLAGS, 8'h80);
      chk({15'h0000, irq[7]}, 16'h0000);
      reg_wr(TCC_ADDR_TIMER_CTRL, 8'h83);
      chk({15'h0000, irq[7]}, 16'h0001);
      // A mid-run reset must clear the port, compare 0 and the counter, which all hold values now.
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      chk({8'h00, port4}, 16'h0000);
      rd16(TCC_ADDR_CMP_BASE, c1);
      chk(c1, 16'h0000);
      rd16(TCC_ADDR_CNT_LO, c1);
      chk(c1, 16'h0000);
      end_sim();
   end
endmodule : tcc_unit_tb
